// ---- rtc_cfg_regs.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef RTC_CFG_REGS_SVH
`define RTC_CFG_REGS_SVH
`define CFG_OFFSET 12'h000
`define VAL_HIGH_OFFSET 12'h004
`define VAL_LOW_OFFSET 12'h008
`define RUN_BIT 15
`define UNLOCK_BIT 13
`define RIPPLE_BIT 12
`define HALF_BIT 11
`define OUT_ON_BIT 10
`define PTR_MSB 9
`define PTR_LSB 8
`define CAL_MSB 7
`define CAL_LSB 0
`define BYTE_MSB 7
`define CFG_W 16
`define CFG_RESET 16'h0000
`define BYTE_RESET 8'h00
`define PTR_ZERO 2'h0
`define PTR_STEP 2'h1
`define LANE_HIGH 1'b1
`define LANE_LOW 1'b0
`define IDX_SEC 3'h0
`define IDX_MIN 3'h1
`define IDX_HOUR 3'h2
`define IDX_RSVD 3'h7
`define SEC_MAX 8'h3B
`define MIN_MAX 8'h3B
`define HOUR_MAX 8'h17
`define CLK_HZ 25000000
`define SECOND_S 1
`define RIPPLE_CYCLES 8
`endif

// ---- rtc_cfg_pkg.sv ----
// types shared by the clock configuration block
package rtc_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    sel_minutes = 2'b00,
    sel_weekday = 2'b01,
    sel_month = 2'b10,
    sel_year = 2'b11
  } window_sel_e;
endpackage : rtc_cfg_pkg

// ---- rtc_config_and_value_window.sv ----
// apb configuration register and time value window of the clock block
`timescale 1ns/1ps
`include "rtc_cfg_regs.svh"

// Overview of operation
// - run enable writable only while unlocked
// - value registers writable only while unlocked
// - ripple flag warns reads may tear
// - half second flag shows second half
// - seconds write clears half second flag
// - clock output driven only when enabled
// - high value access decrements pointer, stops zero
// - pointer selects fields shown in window
module rtc_config_and_value_window #(
  parameter int TICKS_PER_SEC = `CLK_HZ * `SECOND_S,
  parameter int PRESC_W = 25
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic count_enable,
  output logic time_out,
  output logic time_out_en
);
  localparam logic [PRESC_W-1:0] TERM_BASE = PRESC_W'(TICKS_PER_SEC - 1);
  localparam logic [PRESC_W-1:0] HALF_COUNT = PRESC_W'(TICKS_PER_SEC / 2);
  localparam logic [PRESC_W-1:0] RIPPLE_LEAD = PRESC_W'(`RIPPLE_CYCLES);

  logic run_en, unlock, out_on, ripple, half;
  logic [1:0] ptr;
  rtc_cfg_pkg::byte_t cal;
  rtc_cfg_pkg::byte_t value_mem [0:7];
  logic [PRESC_W-1:0] presc;

  logic next_run_en, next_unlock, next_out_on, next_ripple, next_half;
  logic [1:0] next_ptr;
  rtc_cfg_pkg::byte_t next_cal;
  rtc_cfg_pkg::byte_t next_value_mem [0:7];
  logic [PRESC_W-1:0] next_presc;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_time_out;

  logic hit_cfg, hit_hi, hit_lo, setup, done, wr, rd, wr_val, sec_wr, tick;
  logic [2:0] wr_idx, rd_idx;
  logic [PRESC_W-1:0] term;
  rtc_cfg_pkg::byte_t wdata_b;
  logic [`CFG_W-1:0] cfg_view;

  assign hit_cfg = paddr == `CFG_OFFSET;
  assign hit_hi = paddr == `VAL_HIGH_OFFSET;
  assign hit_lo = paddr == `VAL_LOW_OFFSET;
  assign setup = psel & ~penable;
  assign done = psel & penable & pready;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign wdata_b = pwdata[`BYTE_MSB:0];
  assign wr_idx = {ptr, hit_hi};
  assign rd_idx = {ptr, hit_hi};
  assign wr_val = wr & (hit_hi | hit_lo) & unlock & (wr_idx != `IDX_RSVD);
  assign sec_wr = wr_val & (wr_idx == `IDX_SEC);
  // first second of each minute is shortened or stretched by the trim
  assign term = (value_mem[`IDX_SEC] == `BYTE_RESET)
    ? TERM_BASE - {{(PRESC_W-8){cal[`CAL_MSB]}}, cal} : TERM_BASE;
  assign tick = run_en & (presc >= term);

  always_comb begin
    cfg_view = `CFG_RESET;
    cfg_view[`RUN_BIT] = run_en;
    cfg_view[`UNLOCK_BIT] = unlock;
    cfg_view[`RIPPLE_BIT] = ripple;
    cfg_view[`HALF_BIT] = half;
    cfg_view[`OUT_ON_BIT] = out_on;
    cfg_view[`PTR_MSB:`PTR_LSB] = ptr;
    cfg_view[`CAL_MSB:`CAL_LSB] = cal;
  end

  // configuration and pointer
  always_comb begin
    next_run_en = run_en;
    next_unlock = unlock;
    next_out_on = out_on;
    next_ptr = ptr;
    next_cal = cal;
    if (wr & hit_cfg) begin
      next_unlock = pwdata[`UNLOCK_BIT];
      next_out_on = pwdata[`OUT_ON_BIT];
      next_ptr = pwdata[`PTR_MSB:`PTR_LSB];
      next_cal = pwdata[`CAL_MSB:`CAL_LSB];
      if (unlock) begin
        next_run_en = pwdata[`RUN_BIT];
      end
    end
    if ((wr | rd) & hit_hi & (ptr != `PTR_ZERO)) begin
      next_ptr = ptr - `PTR_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en <= 1'b0;
      unlock <= 1'b0;
      out_on <= 1'b0;
      ptr <= `PTR_ZERO;
      cal <= `BYTE_RESET;
    end else begin
      run_en <= next_run_en;
      unlock <= next_unlock;
      out_on <= next_out_on;
      ptr <= next_ptr;
      cal <= next_cal;
    end
  end

  // timekeeping: prescaler and time bytes
  always_comb begin
    next_value_mem = value_mem;
    next_presc = presc;
    if (tick) begin
      next_presc = '0;
      if (value_mem[`IDX_SEC] >= `SEC_MAX) begin
        next_value_mem[`IDX_SEC] = `BYTE_RESET;
        if (value_mem[`IDX_MIN] >= `MIN_MAX) begin
          next_value_mem[`IDX_MIN] = `BYTE_RESET;
          if (value_mem[`IDX_HOUR] >= `HOUR_MAX) begin
            next_value_mem[`IDX_HOUR] = `BYTE_RESET;
          end else begin
            next_value_mem[`IDX_HOUR] = value_mem[`IDX_HOUR] + 8'h01;
          end
        end else begin
          next_value_mem[`IDX_MIN] = value_mem[`IDX_MIN] + 8'h01;
        end
      end else begin
        next_value_mem[`IDX_SEC] = value_mem[`IDX_SEC] + 8'h01;
      end
    end else if (run_en) begin
      next_presc = presc + PRESC_W'(1);
    end
    if (wr_val) begin
      next_value_mem[wr_idx] = wdata_b;
    end
    if (sec_wr) begin
      next_presc = '0;
    end
    next_half = next_presc >= HALF_COUNT;
    next_ripple = next_run_en & (next_presc + RIPPLE_LEAD >= term);
    next_time_out = next_out_on & next_half;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        value_mem[i] <= `BYTE_RESET;
      end
      presc <= '0;
      half <= 1'b0;
      ripple <= 1'b0;
      time_out <= 1'b0;
      time_out_en <= 1'b0;
      count_enable <= 1'b0;
    end else begin
      value_mem <= next_value_mem;
      presc <= next_presc;
      half <= next_half;
      ripple <= next_ripple;
      time_out <= next_time_out;
      time_out_en <= next_out_on;
      count_enable <= next_run_en;
    end
  end

  // apb answer, zero wait states
  always_comb begin
    next_pready = setup;
    next_pslverr = setup & ~(hit_cfg | hit_hi | hit_lo);
    next_prdata = prdata;
    if (setup) begin
      next_prdata = '0;
      if (hit_cfg) begin
        next_prdata[`CFG_W-1:0] = cfg_view;
      end else if ((hit_hi | hit_lo) & (rd_idx != `IDX_RSVD)) begin
        next_prdata[`BYTE_MSB:0] = value_mem[rd_idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hi_access;
    done & hit_hi;
  endsequence
  sequence hi_read_setup;
    setup & ~pwrite & hit_hi;
  endsequence
  sequence lo_read_setup;
    setup & ~pwrite & hit_lo;
  endsequence
  sequence cfg_write;
    wr & hit_cfg;
  endsequence
  sequence sec_rollover;
    tick & (value_mem[`IDX_SEC] >= `SEC_MAX);
  endsequence

  chk_run_locked: assert property (wr & hit_cfg & ~unlock |=> run_en == $past(run_en))
    else $error("run enable changed while locked");
  chk_value_locked: assert property (wr & (hit_hi | hit_lo) & ~unlock & ~run_en
    |=> value_mem[$past(wr_idx)] == $past(value_mem[wr_idx]))
    else $error("value byte changed while locked");
  chk_value_write: assert property (wr_val |=> value_mem[$past(wr_idx)] == $past(wdata_b))
    else $error("unlocked value write lost");
  chk_ripple_run: assert property (ripple |-> run_en ##1 1)
    else $error("ripple flag while stopped");
  chk_half_phase: assert property (half == (presc >= HALF_COUNT))
    else $error("half second flag wrong");
  chk_half_clear: assert property (sec_wr |=> ~half && presc == '0)
    else $error("seconds write did not clear half flag");
  chk_out_gate: assert property (~time_out_en |-> ~time_out)
    else $error("clock output while disabled");
  chk_ptr_step: assert property (hi_access ##0 (ptr != `PTR_ZERO)
    |=> ptr == $past(ptr) - `PTR_STEP)
    else $error("pointer did not decrement");
  chk_ptr_floor: assert property (hi_access ##0 (ptr == `PTR_ZERO) |=> ptr == `PTR_ZERO)
    else $error("pointer moved below zero");
  chk_window_rsvd: assert property (hi_read_setup
    ##0 (ptr == rtc_cfg_pkg::sel_year) |=> prdata == '0)
    else $error("reserved window not zero");
  chk_run_stop: assert property (~run_en & ~sec_wr |=> $stable(presc))
    else $error("prescaler moved while stopped");
  chk_cal_write: assert property (wr & hit_cfg |=> cal == $past(pwdata[`CAL_MSB:`CAL_LSB]))
    else $error("calibration write lost");

  // configuration and window checks
  chk_run_unlocked: assert property (cfg_write ##0 unlock
    |=> run_en == $past(pwdata[`RUN_BIT]))
    else $error("run enable write lost while unlocked");
  chk_unlock_write: assert property (cfg_write
    |=> unlock == $past(pwdata[`UNLOCK_BIT]))
    else $error("unlock write lost");
  chk_locked_noerr: assert property (setup & (hit_hi | hit_lo) |=> ~pslverr)
    else $error("value register access flagged as error");
  chk_ripple_stop: assert property (~run_en |-> ~ripple)
    else $error("ripple flag set while stopped");
  chk_half_tick: assert property (tick |=> ~half)
    else $error("half second flag set after tick");
  chk_half_read: assert property (setup & hit_cfg
    |=> prdata[`HALF_BIT] == $past(half))
    else $error("half second flag misread");
  chk_out_write: assert property (cfg_write
    |=> time_out_en == $past(pwdata[`OUT_ON_BIT]))
    else $error("output enable write lost");
  chk_out_phase: assert property (time_out == (time_out_en & half))
    else $error("clock output not on half second phase");
  chk_ptr_hold: assert property (~(done & hit_hi) & ~(wr & hit_cfg)
    |=> $stable(ptr))
    else $error("pointer moved without access");
  chk_window_high: assert property (hi_read_setup
    ##0 (ptr != rtc_cfg_pkg::sel_year) |=> prdata == {24'h0, $past(value_mem[rd_idx])})
    else $error("high window byte wrong");
  chk_window_low: assert property (lo_read_setup
    |=> prdata == {24'h0, $past(value_mem[rd_idx])})
    else $error("low window byte wrong");

  // timekeeping checks
  chk_sec_step: assert property (tick & ~wr_val & (value_mem[`IDX_SEC] < `SEC_MAX)
    |=> value_mem[`IDX_SEC] == $past(value_mem[`IDX_SEC]) + 8'h01)
    else $error("seconds did not advance");
  chk_sec_wrap: assert property (sec_rollover ##0 ~wr_val
    |=> value_mem[`IDX_SEC] == `BYTE_RESET)
    else $error("seconds did not wrap");
  chk_min_carry: assert property (sec_rollover
    ##0 ~wr_val & (value_mem[`IDX_MIN] < `MIN_MAX)
    |=> value_mem[`IDX_MIN] == $past(value_mem[`IDX_MIN]) + 8'h01)
    else $error("minutes did not carry");
  chk_presc_count: assert property (run_en & ~tick & ~sec_wr
    |=> presc == $past(presc) + PRESC_W'(1))
    else $error("prescaler did not count");
  chk_tick_presc: assert property (tick |=> presc == '0)
    else $error("prescaler not restarted on tick");
  chk_run_mirror: assert property (count_enable == run_en)
    else $error("count enable output out of step");
  chk_trim_plain: assert property (value_mem[`IDX_SEC] != `BYTE_RESET
    |-> term == TERM_BASE)
    else $error("trim applied outside second zero");
  chk_cal_hold: assert property (~(wr & hit_cfg) |=> $stable(cal))
    else $error("calibration changed without write");
endmodule : rtc_config_and_value_window

// ---- tb_rtc_config_and_value_window.sv ----
// self-checking bench of the clock configuration block
`timescale 1ns/1ps
module tb_rtc_config_and_value_window;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, count_enable, time_out, time_out_en, err;
  int num_errors = 0, comparisons = 0, seed = 95856;
  logic [7:0] trim, sec, vh [4], vl [4];
  rtc_config_and_value_window #(.TICKS_PER_SEC(40)) u_rtc_config_and_value_window (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_enable(count_enable), .time_out(time_out), .time_out_en(time_out_en));
  always #20 pclk = ~pclk;
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cfg(input logic run, input logic unl, input logic oe,
                                      input logic [1:0] p, input logic [7:0] t);
    return {16'h0000, run, 1'b0, unl, 2'b00, oe, p, t};
  endfunction : cfg
  task stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
  initial begin
    trim = 8'($random(seed));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg_reset", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h008, 32'h15);
    apb(1'b0, 12'h008, 32'h0);
    chk("locked_write", rd, 32'h0);
    apb(1'b1, 12'h000, cfg(1'b1, 1'b0, 1'b0, 2'h0, trim));
    apb(1'b1, 12'h000, cfg(1'b1, 1'b1, 1'b0, 2'h0, trim));
    repeat (2) @(negedge pclk);
    chk("run_locked", {31'h0, count_enable}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg_trim", rd, cfg(1'b0, 1'b1, 1'b0, 2'h0, trim));
    for (int p = 3; p >= 0; p--) begin
      vl[p] = 8'({$random(seed)} % (p == 1 ? 24 : 60));
      vh[p] = (p == 3) ? 8'h00 : 8'({$random(seed)} % 12 + 1);
      apb(1'b1, 12'h000, cfg(1'b0, 1'b1, 1'b0, 2'(p), trim));
      apb(1'b1, 12'h008, {24'h0, vl[p]});
      apb(1'b1, 12'h004, (p == 3) ? 32'h5A : {24'h0, vh[p]});
      apb(1'b0, 12'h000, 32'h0);
      chk("ptr_dec", {30'h0, rd[9:8]}, (p == 0) ? 32'h0 : 32'(p - 1));
    end
    for (int p = 3; p >= 0; p--) begin
      apb(1'b1, 12'h000, cfg(1'b0, 1'b1, 1'b0, 2'(p), trim));
      apb(1'b0, 12'h008, 32'h0);
      chk("win_low", rd, {24'h0, vl[p]});
      apb(1'b0, 12'h004, 32'h0);
      chk("win_high", rd, {24'h0, vh[p]});
    end
    apb(1'b0, 12'h004, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("ptr_stop", rd, cfg(1'b0, 1'b1, 1'b0, 2'h0, trim));
    sec = 8'({$random(seed)} % 50 + 1);
    apb(1'b1, 12'h000, cfg(1'b1, 1'b1, 1'b1, 2'h0, trim));
    apb(1'b1, 12'h008, {24'h0, sec});
    apb(1'b0, 12'h000, 32'h0);
    chk("half_clear", {31'h0, rd[11]}, 32'h0);
    chk("run_on", {30'h0, count_enable, time_out_en}, 32'h3);
    repeat (20) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("half_late", {30'h0, rd[12:11]}, 32'h1);
    @(negedge pclk);
    chk("out_follow", {31'h0, time_out}, 32'h1);
    repeat (6) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ripple", {30'h0, rd[12:11]}, 32'h3);
    repeat (10) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("sec_tick", rd, {24'h0, sec + 8'h01});
    apb(1'b1, 12'h000, cfg(1'b1, 1'b1, 1'b0, 2'h0, trim));
    repeat (2) @(negedge pclk);
    chk("out_off", {30'h0, time_out_en, time_out}, 32'h0);
    apb(1'b1, 12'h000, cfg(1'b0, 1'b1, 1'b0, 2'h0, trim));
    apb(1'b0, 12'h008, 32'h0);
    sec = rd[7:0];
    repeat (100) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("held", rd, {24'h0, sec});
    chk("run_off", {31'h0, count_enable}, 32'h0);
    apb(1'b1, 12'h000, cfg(1'b0, 1'b1, 1'b0, 2'h0, 8'h05));
    apb(1'b1, 12'h008, 32'h3B);
    apb(1'b1, 12'h000, cfg(1'b1, 1'b1, 1'b0, 2'h0, 8'h05));
    repeat (70) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("trim_sec0", rd, 32'h0);
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("trim_short", rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("min_carry", rd, {24'h0, vh[0] + 8'h01});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("rst_cfg", rd, 32'h0);
    chk("rst_run", {31'h0, count_enable}, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("rst_min", rd, 32'h0);
    stop_test();
  end
endmodule : tb_rtc_config_and_value_window
